// File: hdl/dpll_pkg.sv
// package: constants and carrier types for the dpll back end
// What this block does
// - lock flagged when level exceeds +1024
// - unlock flagged when level drops below -1024
// - fill or drain uses error magnitude only
// - free-run or holdover forces phase unlock
// - switchover freezes lock state
// - frequency detector uses same bucket on period
// - period magnitude compared to 24-bit threshold
// - 48-bit accumulator adds tuning word, wraps
// - 16-bit phase offset added to accumulator
// - 10-bit dac scaling word held, driven out
// - free-run takes programmed tuning word
// - closed loop takes loop filter word
// - holdover takes averaged history word once one exists
// - clamp bounds frequency in every mode
// - limits are 24-bit fractions of rate
// - reset limits span zero to sample rate
// - average loop words over millisecond interval
// - per sample add fill or subtract drain
// - level saturates between -2048 and +2048
// - level between marks keeps indication
// - fill and drain are 8-bit each
package dpll_pkg;
   localparam int ACC_W   = 48;
   localparam int LIM_W   = 24;
   localparam int PH_W    = 16;
   localparam int DAC_W   = 10;
   localparam int ERR_W   = 24;
   localparam int LVL_W   = 14;
   localparam int CNT_W   = 32;
   localparam int SUM_W   = ACC_W + CNT_W;
   localparam logic signed [LVL_W-1:0] LVL_FULL  = 14'sh0800;
   localparam logic signed [LVL_W-1:0] LVL_EMPTY = 14'sh3800;
   localparam logic signed [LVL_W-1:0] MARK_HI   = 14'sh0400;
   localparam logic signed [LVL_W-1:0] MARK_LO   = 14'sh3c00;
   localparam logic [15:0] DAC_OFF   = 16'h0213;
   localparam logic [15:0] FTW_OFF   = 16'h0300;
   localparam logic [15:0] CLAMP_OFF = 16'h0307;
   localparam logic [15:0] PHOFF_OFF = 16'h030d;
   localparam logic [15:0] HIST_OFF  = 16'h0318;
   localparam int DAC_BYTES   = 2;
   localparam int FTW_BYTES   = 6;
   localparam int CLAMP_BYTES = 6;
   localparam int PHOFF_BYTES = 2;
   localparam int HIST_BYTES  = 3;
   localparam logic [DAC_W-1:0] DAC_RST    = 10'h000;
   localparam logic [ACC_W-1:0] FTW_RST    = 48'h000000000000;
   localparam logic [LIM_W-1:0] LIM_LO_RST = 24'h000000;
   localparam logic [LIM_W-1:0] LIM_HI_RST = 24'hffffff;
   localparam logic [PH_W-1:0]  PHOFF_RST  = 16'h0000;
   localparam logic [LIM_W-1:0] HIST_RST   = 24'h000001;
   localparam logic [LIM_W-1:0] LOW_ONES   = 24'hffffff;
   localparam logic [LIM_W-1:0] LOW_ZERO   = 24'h000000;
   // timing: clock rate and the history time unit
   localparam int CLK_MHZ      = 100;
   localparam int HIST_UNIT_US = 1000;
   localparam int MS_CYCLES    = HIST_UNIT_US * CLK_MHZ;
   typedef enum logic [1:0] {
      MODE_FREE   = 2'b00,
      MODE_CLOSED = 2'b01,
      MODE_HOLD   = 2'b11
   } loop_mode_type;
   typedef struct packed {
      logic [LIM_W-1:0] thr;
      logic [7:0]       fill;
      logic [7:0]       drain;
   } lock_cfg_type;
endpackage

// File: hdl/dpll_backend.sv
// dpll back end: lock detectors, tuning select, clamp, synthesizer, timer
`timescale 1ns/100ps

// leaky-bucket lock detector, shared by phase and frequency paths
module lock_bucket (
   input  wire logic                              sys_clk,
   input  wire logic                              reset,
   input  wire logic                              err_valid,
   input  wire logic signed [dpll_pkg::ERR_W-1:0] err,
   input  wire dpll_pkg::lock_cfg_type            cfg,
   input  wire logic                              force_unlock,
   input  wire logic                              hold,
   output logic                                   locked_r
);
   logic        [dpll_pkg::ERR_W-1:0] mag;
   logic                              in_band;
   logic signed [dpll_pkg::LVL_W-1:0] sum;
   logic signed [dpll_pkg::LVL_W-1:0] level_r;
   logic signed [dpll_pkg::LVL_W-1:0] level_nxt;

   // sign dropped; most negative code still maps to its magnitude
   always_comb begin
      mag     = err[dpll_pkg::ERR_W-1] ? dpll_pkg::ERR_W'(-err) : err;
      in_band = mag <= cfg.thr;
   end

   // one fill or one drain per sample, then saturate
   always_comb begin
      if (in_band) begin
         sum = level_r + $signed({6'h00, cfg.fill});
      end else begin
         sum = level_r - $signed({6'h00, cfg.drain});
      end
      if (sum > dpll_pkg::LVL_FULL) begin
         level_nxt = dpll_pkg::LVL_FULL;
      end else if (sum < dpll_pkg::LVL_EMPTY) begin
         level_nxt = dpll_pkg::LVL_EMPTY;
      end else begin
         level_nxt = sum;
      end
   end

   // level: frozen over switchover, emptied when loop is open
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         level_r <= dpll_pkg::LVL_EMPTY;
      end else if (hold) begin
         level_r <= level_r;
      end else if (force_unlock) begin
         level_r <= dpll_pkg::LVL_EMPTY;
      end else if (err_valid) begin
         level_r <= level_nxt;
      end
   end

   // indication with hysteresis between the marks
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         locked_r <= 1'b0;
      end else if (hold) begin
         locked_r <= locked_r;
      end else if (force_unlock) begin
         locked_r <= 1'b0;
      end else if (level_r > dpll_pkg::MARK_HI) begin
         locked_r <= 1'b1;
      end else if (level_r < dpll_pkg::MARK_LO) begin
         locked_r <= 1'b0;
      end
   end

   property p_lock_up;
      @(posedge sys_clk) disable iff (reset)
      !hold && !force_unlock && level_r > dpll_pkg::MARK_HI |=> locked_r;
   endproperty
   a_lock_up: assert property (p_lock_up) else $error("no lock above high mark");

   property p_lock_down;
      @(posedge sys_clk) disable iff (reset)
      !hold && level_r < dpll_pkg::MARK_LO |=> !locked_r;
   endproperty
   a_lock_down: assert property (p_lock_down) else $error("lock kept below low mark");

   property p_force;
      @(posedge sys_clk) disable iff (reset)
      force_unlock && !hold |=> !locked_r ##1 (!locked_r || !force_unlock || hold);
   endproperty
   a_force: assert property (p_force) else $error("locked while loop open");

   property p_hold;
      @(posedge sys_clk) disable iff (reset)
      hold |=> $stable(locked_r) && $stable(level_r);
   endproperty
   a_hold: assert property (p_hold) else $error("state moved during switchover");

   property p_range;
      @(posedge sys_clk) disable iff (reset)
      level_r <= dpll_pkg::LVL_FULL && level_r >= dpll_pkg::LVL_EMPTY;
   endproperty
   a_range: assert property (p_range) else $error("bucket level out of range");

   property p_fill;
      @(posedge sys_clk) disable iff (reset)
      err_valid && !hold && !force_unlock && in_band && level_r < 14'sh0700
      |=> level_r == $past(level_r) + $signed({6'h00, $past(cfg.fill)});
   endproperty
   a_fill: assert property (p_fill) else $error("fill amount not added");

   property p_between;
      @(posedge sys_clk) disable iff (reset)
      !force_unlock && level_r <= dpll_pkg::MARK_HI && level_r >= dpll_pkg::MARK_LO
      |=> $stable(locked_r);
   endproperty
   a_between: assert property (p_between) else $error("indication changed between marks");

   c_locked: cover property (@(posedge sys_clk) disable iff (reset) $rose(locked_r));
endmodule

// two-entry skid buffer; no word lost when the sink stalls
module skid_buffer #(
   parameter int WIDTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready_r,
   output logic                  out_valid_r,
   output logic      [WIDTH-1:0] out_data_r,
   input  wire logic             out_ready
);
   logic [WIDTH-1:0] skid_r;
   logic             skid_valid_r;
   logic             take;

   assign take = in_valid && in_ready_r;

   // output slot refills from skid first, keeping order
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         out_valid_r  <= 1'b0;
         out_data_r   <= '0;
         skid_valid_r <= 1'b0;
         skid_r       <= '0;
      end else if (!out_valid_r || out_ready) begin
         if (skid_valid_r) begin
            out_data_r   <= skid_r;
            out_valid_r  <= 1'b1;
            skid_valid_r <= 1'b0;
         end else begin
            out_data_r  <= in_data;
            out_valid_r <= take;
         end
      end else if (take) begin
         skid_r       <= in_data;
         skid_valid_r <= 1'b1;
      end
   end

   // ready is registered: full once the skid slot holds a word
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         in_ready_r <= 1'b1;
      end else begin
         in_ready_r <= !(skid_valid_r ? !(out_ready || !out_valid_r)
                                      : (take && out_valid_r && !out_ready));
      end
   end
endmodule

module dpll_backend #(
   parameter int MS_CYCLES = dpll_pkg::MS_CYCLES
) (
   input  wire logic                              sys_clk,
   input  wire logic                              reset,
   input  wire logic                   [15:0]     reg_addr,
   input  wire logic                   [7:0]      reg_wdata,
   input  wire logic                              reg_write,
   input  wire logic                              reg_read,
   output logic                        [7:0]      reg_rdata_r,
   input  wire dpll_pkg::loop_mode_type           loop_mode,
   input  wire logic                              switchover,
   input  wire logic                              phase_err_valid,
   input  wire logic signed [dpll_pkg::ERR_W-1:0] phase_err,
   input  wire dpll_pkg::lock_cfg_type            phase_cfg,
   input  wire logic                              period_err_valid,
   input  wire logic signed [dpll_pkg::ERR_W-1:0] period_err,
   input  wire dpll_pkg::lock_cfg_type            freq_cfg,
   input  wire logic                              lf_valid,
   input  wire logic        [dpll_pkg::ACC_W-1:0] lf_word,
   input  wire logic                              dac_ready,
   output logic                                   dac_valid_r,
   output logic             [dpll_pkg::PH_W-1:0]  dac_phase_r,
   output logic             [dpll_pkg::DAC_W-1:0] full_scale_current_r,
   output logic                                   phase_locked_r,
   output logic                                   freq_locked_r,
   output logic                                   hist_strobe_r
);
   localparam int MS_W = $clog2(MS_CYCLES + 1);
   logic [dpll_pkg::ACC_W-1:0]   freq_step_word_r;
   logic [2*dpll_pkg::LIM_W-1:0] clamp_r;
   logic [dpll_pkg::PH_W-1:0]    phoff_r;
   logic [dpll_pkg::LIM_W-1:0]   ivl_len_r;
   logic [dpll_pkg::ACC_W-1:0]   acc_r;
   logic [dpll_pkg::ACC_W-1:0]   ftw_sel;
   logic [dpll_pkg::ACC_W-1:0]   ftw_clamped;
   logic [dpll_pkg::LIM_W-1:0]   lim_lo;
   logic [dpll_pkg::LIM_W-1:0]   lim_hi;
   logic [dpll_pkg::ACC_W-1:0]   hist_word_r;
   logic                         hist_valid_r;
   logic [dpll_pkg::SUM_W-1:0]   sum_r;
   logic [dpll_pkg::CNT_W-1:0]   cnt_r;
   logic [MS_W-1:0]              ms_cnt_r;
   logic [dpll_pkg::LIM_W-1:0]   ivl_r;
   logic                         ms_tick;
   logic                         ivl_end;
   logic                         loop_open;
   logic                         buf_ready;
   logic                         sample_in;

   assign lim_lo    = clamp_r[dpll_pkg::LIM_W-1:0];
   assign lim_hi    = clamp_r[2*dpll_pkg::LIM_W-1:dpll_pkg::LIM_W];
   assign loop_open = loop_mode != dpll_pkg::MODE_CLOSED;
   assign sample_in = lf_valid && loop_mode == dpll_pkg::MODE_CLOSED;

   // register writes; multi-byte words are little-endian
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         full_scale_current_r <= dpll_pkg::DAC_RST;
         freq_step_word_r     <= dpll_pkg::FTW_RST;
         clamp_r              <= {dpll_pkg::LIM_HI_RST, dpll_pkg::LIM_LO_RST};
         phoff_r              <= dpll_pkg::PHOFF_RST;
         ivl_len_r            <= dpll_pkg::HIST_RST;
      end else if (reg_write) begin
         if (reg_addr == dpll_pkg::DAC_OFF) begin
            full_scale_current_r[7:0] <= reg_wdata;
         end
         if (reg_addr == dpll_pkg::DAC_OFF + 16'h0001) begin
            full_scale_current_r[9:8] <= reg_wdata[1:0];
         end
         if (reg_addr >= dpll_pkg::FTW_OFF && reg_addr < dpll_pkg::FTW_OFF + 16'(dpll_pkg::FTW_BYTES)) begin
            freq_step_word_r[8*3'(reg_addr - dpll_pkg::FTW_OFF) +: 8] <= reg_wdata;
         end
         if (reg_addr >= dpll_pkg::CLAMP_OFF && reg_addr < dpll_pkg::CLAMP_OFF + 16'(dpll_pkg::CLAMP_BYTES)) begin
            clamp_r[8*3'(reg_addr - dpll_pkg::CLAMP_OFF) +: 8] <= reg_wdata;
         end
         if (reg_addr >= dpll_pkg::PHOFF_OFF && reg_addr < dpll_pkg::PHOFF_OFF + 16'(dpll_pkg::PHOFF_BYTES)) begin
            phoff_r[8*1'(reg_addr - dpll_pkg::PHOFF_OFF) +: 8] <= reg_wdata;
         end
         if (reg_addr >= dpll_pkg::HIST_OFF && reg_addr < dpll_pkg::HIST_OFF + 16'(dpll_pkg::HIST_BYTES)) begin
            ivl_len_r[8*2'(reg_addr - dpll_pkg::HIST_OFF) +: 8] <= reg_wdata;
         end
      end
   end

   // register reads; unmapped bytes return zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_read) begin
         reg_rdata_r <= 8'h00;
         if (reg_addr == dpll_pkg::DAC_OFF) begin
            reg_rdata_r <= full_scale_current_r[7:0];
         end
         if (reg_addr == dpll_pkg::DAC_OFF + 16'h0001) begin
            reg_rdata_r <= {6'h00, full_scale_current_r[9:8]};
         end
         if (reg_addr >= dpll_pkg::FTW_OFF && reg_addr < dpll_pkg::FTW_OFF + 16'(dpll_pkg::FTW_BYTES)) begin
            reg_rdata_r <= freq_step_word_r[8*3'(reg_addr - dpll_pkg::FTW_OFF) +: 8];
         end
         if (reg_addr >= dpll_pkg::CLAMP_OFF && reg_addr < dpll_pkg::CLAMP_OFF + 16'(dpll_pkg::CLAMP_BYTES)) begin
            reg_rdata_r <= clamp_r[8*3'(reg_addr - dpll_pkg::CLAMP_OFF) +: 8];
         end
         if (reg_addr >= dpll_pkg::PHOFF_OFF && reg_addr < dpll_pkg::PHOFF_OFF + 16'(dpll_pkg::PHOFF_BYTES)) begin
            reg_rdata_r <= phoff_r[8*1'(reg_addr - dpll_pkg::PHOFF_OFF) +: 8];
         end
         if (reg_addr >= dpll_pkg::HIST_OFF && reg_addr < dpll_pkg::HIST_OFF + 16'(dpll_pkg::HIST_BYTES)) begin
            reg_rdata_r <= ivl_len_r[8*2'(reg_addr - dpll_pkg::HIST_OFF) +: 8];
         end
      end
   end

   // lock detectors; switchover outranks the open-loop unlock
   lock_bucket u_phase_lock (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .err_valid    (phase_err_valid),
      .err          (phase_err),
      .cfg          (phase_cfg),
      .force_unlock (loop_open),
      .hold         (switchover),
      .locked_r     (phase_locked_r)
   );
   lock_bucket u_freq_lock (
      .sys_clk      (sys_clk),
      .reset        (reset),
      .err_valid    (period_err_valid),
      .err          (period_err),
      .cfg          (freq_cfg),
      .force_unlock (loop_open),
      .hold         (switchover),
      .locked_r     (freq_locked_r)
   );

   // tuning word source; no history yet falls back to free-run word
   always_comb begin
      unique case (loop_mode)
         dpll_pkg::MODE_FREE:   ftw_sel = freq_step_word_r;
         dpll_pkg::MODE_CLOSED: ftw_sel = lf_word;
         dpll_pkg::MODE_HOLD:   ftw_sel = hist_valid_r ? hist_word_r : freq_step_word_r;
         default:               ftw_sel = freq_step_word_r;
      endcase
   end

   // clamp on the upper 24 bits; upper bound keeps low bits all ones
   always_comb begin
      if (ftw_sel[dpll_pkg::ACC_W-1:dpll_pkg::LIM_W] > lim_hi) begin
         ftw_clamped = {lim_hi, dpll_pkg::LOW_ONES};
      end else if (ftw_sel[dpll_pkg::ACC_W-1:dpll_pkg::LIM_W] < lim_lo) begin
         ftw_clamped = {lim_lo, dpll_pkg::LOW_ZERO};
      end else begin
         ftw_clamped = ftw_sel;
      end
   end

   // accumulator only steps when the buffer takes the sample
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         acc_r <= '0;
      end else if (buf_ready) begin
         acc_r <= acc_r + ftw_clamped;
      end
   end

   skid_buffer #(.WIDTH(dpll_pkg::PH_W)) u_dac_buf (
      .sys_clk     (sys_clk),
      .reset       (reset),
      .in_valid    (1'b1),
      .in_data     (acc_r[dpll_pkg::ACC_W-1 -: dpll_pkg::PH_W] + phoff_r),
      .in_ready_r  (buf_ready),
      .out_valid_r (dac_valid_r),
      .out_data_r  (dac_phase_r),
      .out_ready   (dac_ready)
   );

   // millisecond prescaler and interval counter
   assign ms_tick = ms_cnt_r == MS_W'(MS_CYCLES - 1);
   assign ivl_end = ms_tick && ivl_len_r != '0 && ivl_r + 24'h000001 >= ivl_len_r;

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ms_cnt_r <= '0;
      end else begin
         ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ivl_r         <= '0;
         hist_strobe_r <= 1'b0;
      end else begin
         hist_strobe_r <= ivl_end;
         if (ms_tick) begin
            ivl_r <= ivl_end ? '0 : ivl_r + 24'h000001;
         end
      end
   end

   // memoryless average per interval; divider used once per interval
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sum_r        <= '0;
         cnt_r        <= '0;
         hist_word_r  <= '0;
         hist_valid_r <= 1'b0;
      end else if (ivl_end) begin
         if (cnt_r != '0) begin
            hist_word_r  <= dpll_pkg::ACC_W'(sum_r / dpll_pkg::SUM_W'(cnt_r));
            hist_valid_r <= 1'b1;
         end
         sum_r <= sample_in ? dpll_pkg::SUM_W'(lf_word) : '0;
         cnt_r <= sample_in ? 32'h00000001 : '0;
      end else if (sample_in) begin
         sum_r <= sum_r + dpll_pkg::SUM_W'(lf_word);
         cnt_r <= cnt_r + 32'h00000001;
      end
   end

   property p_accum;
      @(posedge sys_clk) disable iff (reset)
      buf_ready |=> acc_r == $past(acc_r) + $past(ftw_clamped);
   endproperty
   a_accum: assert property (p_accum) else $error("accumulator did not step");

   property p_clamp;
      @(posedge sys_clk) disable iff (reset)
      lim_lo <= lim_hi |-> ftw_clamped[dpll_pkg::ACC_W-1:dpll_pkg::LIM_W] <= lim_hi
                        && ftw_clamped[dpll_pkg::ACC_W-1:dpll_pkg::LIM_W] >= lim_lo;
   endproperty
   a_clamp: assert property (p_clamp) else $error("tuning word outside clamp");

   property p_free;
      @(posedge sys_clk) disable iff (reset)
      loop_mode == dpll_pkg::MODE_FREE && lim_lo == '0 && lim_hi == dpll_pkg::LIM_HI_RST
      |-> ftw_clamped == freq_step_word_r;
   endproperty
   a_free: assert property (p_free) else $error("free-run word not used");

   property p_strobe;
      @(posedge sys_clk) disable iff (reset)
      hist_strobe_r |=> !hist_strobe_r [*2];
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe longer than one cycle");

   c_strobe: cover property (@(posedge sys_clk) disable iff (reset) hist_strobe_r);
   c_stall: cover property (@(posedge sys_clk) disable iff (reset) !buf_ready);
   c_hold_hist: cover property (@(posedge sys_clk) disable iff (reset)
                                loop_mode == dpll_pkg::MODE_HOLD && hist_valid_r);
endmodule

// File: tb/dac_sink.sv
// dac sink model: accepts samples, may stall every other cycle
`timescale 1ns/100ps
module dac_sink (
   input  wire logic        sys_clk,
   input  wire logic        slow,
   input  wire logic        dac_valid_r,
   input  wire logic [15:0] dac_phase_r,
   output logic             dac_ready = 1'b0,
   output logic             got = 1'b0,
   output logic      [15:0] got_data
);
   // slow mode halves the accept rate so the skid buffer fills
   always @(posedge sys_clk) begin
      got <= dac_valid_r & dac_ready;
      got_data <= dac_phase_r;
      dac_ready <= slow ? ~dac_ready : 1'b1;
   end
endmodule

// File: tb/dpll_backend_tb.sv
// self-checking bench for the dpll back end
`timescale 1ns/100ps
module dpll_backend_tb;
   logic                    sys_clk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
   logic [15:0]             reg_addr = 16'h0000, dac_phase_r, got_data;
   logic [7:0]              reg_wdata = 8'h00, reg_rdata_r;
   dpll_pkg::loop_mode_type loop_mode = dpll_pkg::MODE_CLOSED;
   logic                    switchover = 1'b0, pv = 1'b0, fv = 1'b0, lf_valid = 1'b1, slow = 1'b0;
   logic [23:0]             perr = 24'h000000;
   logic [47:0]             lf_word = 48'h000200000000;
   dpll_pkg::lock_cfg_type  cfg = {24'h000064, 8'hff, 8'hff}, fcfg = {24'h100000, 8'hff, 8'hff};
   logic                    dac_ready, dac_valid_r, got, ph_lk, fr_lk, strobe;
   logic [9:0]              fsc;
   int                      mismatches = 0, n_compared = 0;

   dpll_backend #(.MS_CYCLES(4)) dpll_backend_i (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_r(reg_rdata_r),
      .loop_mode(loop_mode), .switchover(switchover), .phase_err_valid(pv), .phase_err(perr),
      .phase_cfg(cfg), .period_err_valid(fv), .period_err(perr), .freq_cfg(fcfg), .lf_valid(lf_valid),
      .lf_word(lf_word), .dac_ready(dac_ready), .dac_valid_r(dac_valid_r), .dac_phase_r(dac_phase_r),
      .full_scale_current_r(fsc), .phase_locked_r(ph_lk), .freq_locked_r(fr_lk), .hist_strobe_r(strobe));
   dac_sink dac_sink_i (.sys_clk(sys_clk), .slow(slow), .dac_valid_r(dac_valid_r),
      .dac_phase_r(dac_phase_r), .dac_ready(dac_ready), .got(got), .got_data(got_data));

   always #5 sys_clk = ~sys_clk;

   task automatic check(string what, logic [47:0] exp, logic [47:0] seen);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // inputs always change 1 ns after the edge
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // idle cycle after each strobe: no double assignment in one step
   task automatic wr(logic [15:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      tick(1);
      reg_write = 1'b0;
      tick(1);
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] exp, string what);
      reg_addr = a;
      reg_read = 1'b1;
      tick(1);
      reg_read = 1'b0;
      check(what, exp, reg_rdata_r);
      tick(1);
   endtask
   task automatic samp(logic fr, logic [23:0] e, int n);
      perr = e;
      repeat (n) begin
         pv = ~fr;
         fv = fr;
         tick(1);
         pv = 1'b0;
         fv = 1'b0;
         tick(1);
      end
      tick(2);
   endtask
   // flush old samples, then compare two successive sample differences
   task automatic step(logic [15:0] exp, string what);
      logic [15:0] a;
      int n;
      n = 0;
      tick(8);
      for (int i = 0; i < 40 && n < 3; i++) begin
         if (got === 1'b1) begin
            if (n > 0) check(what, exp, 16'(got_data - a));
            a = got_data;
            n++;
         end
         tick(1);
      end
      check("samples", 3, n);
   endtask

   task automatic t_regs;
      rd(16'h030c, 8'hff, "clamp_hi");
      rd(16'h0200, 8'h00, "unmapped");
      rd(16'h0307, 8'h00, "clamp_lo");
      wr(16'h0213, 8'h5a);
      wr(16'h0214, 8'h03);
      check("fsc", 10'h35a, fsc);
      $display("t_regs done");
   endtask
   task automatic t_lock;
      samp(0, 24'hffffce, 20); // negative error inside the band
      check("ph_lock", 1, ph_lk);
      samp(0, 24'h0000c8, 12);
      check("ph_hold", 1, ph_lk);
      samp(0, 24'h0000c8, 1);
      check("ph_unlock", 0, ph_lk);
      samp(0, 24'h000064, 20);
      switchover = 1'b1;
      loop_mode = dpll_pkg::MODE_FREE;
      tick(4);
      check("ph_swo", 1, ph_lk);
      switchover = 1'b0;
      tick(3);
      check("ph_free", 0, ph_lk);
      loop_mode = dpll_pkg::MODE_CLOSED;
      samp(1, 24'hf00000, 12); // magnitude equals the threshold
      check("fr_below", 0, fr_lk);
      samp(1, 24'hf00000, 1);
      check("fr_lock", 1, fr_lk);
      $display("t_lock done");
   endtask
   task automatic t_dds;
      logic [15:0] a;
      slow = 1'b1;
      wr(16'h0304, 8'h01);
      loop_mode = dpll_pkg::MODE_FREE;
      step(16'h0001, "free");
      loop_mode = dpll_pkg::MODE_CLOSED;
      step(16'h0002, "closed");
      loop_mode = dpll_pkg::MODE_HOLD;
      step(16'h0002, "hold");
      loop_mode = dpll_pkg::MODE_FREE;
      wr(16'h0308, 8'h03);
      step(16'h0003, "clamp");
      // spare mode code runs as free-run once the clamp is lifted
      loop_mode = dpll_pkg::loop_mode_type'(2'b10);
      wr(16'h0308, 8'h00);
      step(16'h0001, "mode_10");
      // frozen accumulator: the offset alone moves the sample
      wr(16'h0304, 8'h00);
      tick(8);
      a = dac_phase_r;
      wr(16'h030d, 8'h10);
      tick(8);
      check("phoff", 16'(a + 16'h0010), dac_phase_r);
      $display("t_dds done");
   endtask
   task automatic t_hist;
      int n;
      n = 0;
      wr(16'h0318, 8'h02); // nonzero interval only
      tick(12);
      repeat (80) begin
         n += int'(strobe === 1'b1);
         tick(1);
      end
      check("strobes", 10, n);
      $display("t_hist done");
   endtask

   initial begin
      tick(2);
      reset = 1'b0;
      t_regs;
      t_lock;
      t_dds;
      t_hist;
      results;
   end
   // whole run needs well under 2000 cycles
   initial begin
      #100000;
      mismatches++;
      results;
   end
endmodule
